/* File: hw/keyscan_pkg.sv */
/*
 * Constants, carriers and helpers for the keypad scan/event controller.
 * Assumes a single 100 MHz system clock and a byte-wide register port
 * fed by the serial command interpreter outside this block.
 */
package keyscan_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_SETTLE = 8'h01;
  localparam logic [7:0] A_DEBOUNCE = 8'h02;
  localparam logic [7:0] A_DIMS = 8'h03;
  localparam logic [7:0] A_PINS_LO = 8'h04;
  localparam logic [7:0] A_PINS_HI = 8'h05;
  localparam logic [7:0] A_RAW = 8'h06;
  localparam logic [7:0] A_MASKED = 8'h07;
  localparam logic [7:0] A_IRQ_CLR = 8'h08;
  localparam logic [7:0] A_IRQ_MASK = 8'h09;
  localparam logic [7:0] A_CODE0 = 8'h0C;
  localparam logic [7:0] A_EVT = 8'h10;
  localparam logic [7:0] A_CLK_GATE = 8'h8A;
  localparam logic [7:0] A_GLOBAL = 8'h91;
  localparam logic [7:0] A_PINFN = 8'hA7;
  localparam logic [7:0] A_PULLR_LO = 8'hAA;
  localparam logic [7:0] A_PULLR_HI = 8'hAB;
  localparam logic [7:0] A_PULLC_LO = 8'hAC;
  localparam logic [7:0] A_PULLC_HI = 8'hAD;
  // ----------------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EMPTY_CODE = 8'h7F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int FLUSH_BIT = 0;
  localparam int SC_CLR_BIT = 1;
  localparam int RAW_EVT = 0;
  localparam int RAW_SC = 1;
  localparam int RAW_LOST = 2;
  localparam int RAW_W = 3;
  localparam int MULTI_BIT = 7;
  localparam int CLK_EN_BIT = 0;
  localparam int GLOBAL_KPD_BIT = 0;
  localparam int PIN_ROW_LSB = 8;
  localparam int COL_ROT = 6;
  localparam int DIM_ROW_LSB = 4;
  localparam int DIM_COL_LSB = 0;
  localparam int NPIN = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int EVT_W = 8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 100;
  localparam int SCAN_INTERVAL_US = 4000;
  localparam int SCAN_CYCLES_DEF = SCAN_INTERVAL_US * CLK_FREQ_MHZ;
  localparam int TICK_W = 19;
  localparam int TIME_REF_MS = 12;
  localparam logic [15:0] TIME_REF_VAL = 16'h0080;
  localparam logic [15:0] REF_SCANS = 16'(TIME_REF_MS * 1000 / SCAN_INTERVAL_US);

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_SWEEP, SCAN_EMIT} scan_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] settle;
    logic [7:0] debounce;
    logic [7:0] dims;
    logic [15:0] pins;
    logic [7:0] mask;
    logic [7:0] clk_gate;
    logic [7:0] pinfn;
    logic [15:0] pull_r;
    logic [15:0] pull_c;
    logic [2:0] lk;
    logic [7:0] r1;
    logic [7:0] r2;
    scan_state_type st;
    logic [TICK_W-1:0] tick;
    logic [2:0] col;
    logic [5:0] idx;
    logic [63:0] snap;
    logic [63:0] cand;
    logic [63:0] rep;
    logic [7:0] stab;
    logic [3:0] kv;
    logic [3:0][7:0] kc;
    logic sc_flag;
    logic lost;
    logic [7:0] rdata;
  } kp_state_type;

  // Register value to scans of 4 ms, rounded up, never below one
  function automatic logic [7:0] scans_for(input logic [7:0] v);
    logic [15:0] t;
    t = (16'(v) * REF_SCANS + TIME_REF_VAL - 16'h0001) / TIME_REF_VAL;
    scans_for = (t == 16'h0000) ? 8'h01 : t[7:0];
  endfunction : scans_for

  // Event byte: release, zero, row, column; never equals the empty code
  function automatic logic [7:0] make_code(input logic rel, input logic [5:0] idx);
    make_code = {rel, 1'b0, idx[2:0], idx[5:3]};
  endfunction : make_code
endpackage : keyscan_pkg

/* File: hw/keypad_scan_event_controller.sv */
/*
 * Event FIFO and keypad scan/event controller top.
 * Assumes the serial interface issues one-cycle rd/wr strobes on mclk,
 * keeps the address pointer still while addr_hold is high, and that
 * row pins are pulled up outside while a driven column pulls low.
 */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Event FIFO
// ------------------------------------------------------------------
module key_event_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_type;
  fifo_state_type s;
  fifo_state_type n;
  logic do_push;
  logic do_pop;

  assign in_ready = (s.cnt != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];

  always_comb begin
    n = s;
    do_push = in_valid && in_ready;
    do_pop = out_valid && out_ready && !flush;
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end else begin
      if (do_push) begin
        n.mem[s.wp] = in_data;
        n.wp = AW'(s.wp + 1'b1);
      end
      if (do_pop) begin
        n.rp = AW'(s.rp + 1'b1);
      end
      n.cnt = (AW+1)'(s.cnt + do_push - do_pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : key_event_fifo

// ------------------------------------------------------------------
// Keypad scan/event controller
// ------------------------------------------------------------------
// Operation
// - Scan all assigned matrix keys each 4 ms, comparing against last state.
// - Every key press or release becomes one event FIFO entry, or sets the lost flag when the FIFO is full.
// - Key presses are also recorded in four pressed-key code registers.
// - Raw event flag is set while the event FIFO holds entries.
// - Status-change raw flag is set whenever keyboard status changes.
// - Summary bit set when any raw bit set; irq pin follows, masked.
// - Masked status equals raw bits gated by the enable mask, continuously.
// - Reading the event port with an empty FIFO returns 0x7F.
// - Code register read clears status-change flag once all code registers and the event FIFO are emptied.
// - Raw event flag clears when an event port read empties the FIFO.
// - Flush bit empties FIFO and clears raw event and lost flags.
// - Address pointer does not advance on event port reads.
// - Up to four presses kept; later slots set previous multi-key flag.
// - Each pressed-key code register clears when read.
// - Settle value 0x80 means 12 ms.
// - Debounce value 0x80 means 12 ms.
// - Matrix size: rows in upper nibble, columns in lower nibble.
// - Pin assign word 0xFC3F puts rows 7..2 and columns 7..2 in matrix.
// - Pull control words hold two bits per pin.
// - Writing 0x03 to interrupt clear clears pending keyboard flags.
module keypad_scan_event_controller
  import keyscan_pkg::*;
#(
  parameter int SCAN_CYCLES = keyscan_pkg::SCAN_CYCLES_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input keyscan_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_addr_hold,
  // Keyscan link clock
  input wire logic link_clk,
  // Matrix pins
  input wire logic [7:0] matrix_row_pin,
  output logic [7:0] matrix_column_pin_o,
  output logic [7:0] matrix_column_pin_oe,
  // Pad control
  output logic [15:0] pull_rows,
  output logic [15:0] pull_cols,
  output logic [7:0] pin_function,
  // Interrupt
  output logic host_irq_pin_n
);
  import keyscan_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SCAN_CYCLES - 1);

  kp_state_type s;
  kp_state_type n;
  logic lk_rise;
  logic push;
  logic press;
  logic flush;
  logic stall;
  logic ev_ready;
  logic ev_valid;
  logic pop;
  logic [7:0] ev_data;
  logic [7:0] ev_code;
  logic [RAW_W-1:0] raw;
  logic [RAW_W-1:0] masked;
  logic [7:0] row_en;
  logic [7:0] col_en;
  logic [7:0] row_hit;
  logic [7:0] need;
  logic [1:0] slot;
  logic [1:0] rd_slot;
  logic code_rd;

  // ----------------------------------------------------------------
  // Matrix enables from size and pin assignment
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    assign row_en[i] = s.pins[PIN_ROW_LSB+i] &
                       (4'(i) < s.dims[DIM_ROW_LSB +: 4]);
    assign col_en[i] = s.pins[(i+COL_ROT)%NPIN] &
                       (4'(i) < s.dims[DIM_COL_LSB +: 4]);
    // Rows idle high; a pressed key pulls its row to the driven column
    assign row_hit[i] = ~s.r2[i] & row_en[i];
  end

  // ----------------------------------------------------------------
  // Event FIFO
  // ----------------------------------------------------------------
  key_event_fifo #(
    .WIDTH(EVT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_valid(push),
    .in_ready(ev_ready),
    .in_data(ev_code),
    .out_valid(ev_valid),
    .out_ready(pop),
    .out_data(ev_data)
  );

  assign lk_rise = s.lk[1] & ~s.lk[2];
  assign need = (scans_for(s.settle) > scans_for(s.debounce)) ?
                scans_for(s.settle) : scans_for(s.debounce);
  assign ev_code = make_code(~s.cand[s.idx], s.idx);
  assign press = s.cand[s.idx];
  assign flush = reg_req.wr && reg_req.addr == A_IRQ_CLR &&
                 reg_req.wdata[FLUSH_BIT];
  // Emitter pauses on any read or flush so read-clears never race a press
  assign stall = flush || reg_req.rd;
  assign push = (s.st == SCAN_EMIT) && !stall &&
                (s.cand[s.idx] != s.rep[s.idx]);
  assign code_rd = reg_req.rd && reg_req.addr[7:2] == A_CODE0[7:2];
  assign rd_slot = reg_req.addr[1:0];
  assign pop = reg_req.rd && reg_req.addr == A_EVT;
  assign reg_addr_hold = (reg_req.addr == A_EVT);

  // ----------------------------------------------------------------
  // Interrupt chain
  // ----------------------------------------------------------------
  always_comb begin
    raw = '0;
    raw[RAW_EVT] = ev_valid;
    raw[RAW_SC] = s.sc_flag;
    raw[RAW_LOST] = s.lost;
  end
  assign masked = raw & s.mask[RAW_W-1:0];
  assign host_irq_pin_n = ~|masked;

  // First free code slot
  always_comb begin
    slot = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (!s.kv[i]) begin
        slot = 2'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.lk = {s.lk[1:0], link_clk};
    n.r1 = matrix_row_pin;
    n.r2 = s.r1;
    n.tick = (s.tick == TICK_LAST) ? '0 : TICK_W'(s.tick + 1'b1);
    if (reg_req.wr) begin
      case (reg_req.addr)
        A_SETTLE: n.settle = reg_req.wdata;
        A_DEBOUNCE: n.debounce = reg_req.wdata;
        A_DIMS: n.dims = reg_req.wdata;
        A_PINS_LO: n.pins[7:0] = reg_req.wdata;
        A_PINS_HI: n.pins[15:8] = reg_req.wdata;
        A_IRQ_MASK: n.mask = reg_req.wdata;
        A_CLK_GATE: n.clk_gate = reg_req.wdata;
        A_PINFN: n.pinfn = reg_req.wdata;
        A_PULLR_LO: n.pull_r[7:0] = reg_req.wdata;
        A_PULLR_HI: n.pull_r[15:8] = reg_req.wdata;
        A_PULLC_LO: n.pull_c[7:0] = reg_req.wdata;
        A_PULLC_HI: n.pull_c[15:8] = reg_req.wdata;
        A_IRQ_CLR: begin
          if (reg_req.wdata[SC_CLR_BIT]) begin
            n.sc_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (flush) begin
      n.lost = 1'b0;
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        A_SETTLE: n.rdata = s.settle;
        A_DEBOUNCE: n.rdata = s.debounce;
        A_DIMS: n.rdata = s.dims;
        A_PINS_LO: n.rdata = s.pins[7:0];
        A_PINS_HI: n.rdata = s.pins[15:8];
        A_RAW: n.rdata = 8'(raw);
        A_MASKED: n.rdata = 8'(masked);
        A_IRQ_MASK: n.rdata = s.mask;
        A_CLK_GATE: n.rdata = s.clk_gate;
        A_GLOBAL: n.rdata = 8'(|raw) << GLOBAL_KPD_BIT;
        A_PINFN: n.rdata = s.pinfn;
        A_PULLR_LO: n.rdata = s.pull_r[7:0];
        A_PULLR_HI: n.rdata = s.pull_r[15:8];
        A_PULLC_LO: n.rdata = s.pull_c[7:0];
        A_PULLC_HI: n.rdata = s.pull_c[15:8];
        A_EVT: n.rdata = ev_valid ? ev_data : EMPTY_CODE;
        default: n.rdata = RST_BYTE;
      endcase
      if (code_rd) begin
        n.rdata = s.kv[rd_slot] ? s.kc[rd_slot] : EMPTY_CODE;
        n.kv[rd_slot] = 1'b0;
        n.kc[rd_slot] = RST_BYTE;
        if (n.kv == 4'h0 && !ev_valid) begin
          n.sc_flag = 1'b0;
        end
      end
    end
    case (s.st)
      SCAN_IDLE: begin
        // Scans start only with the keyscan clock gate open
        if (s.tick == TICK_LAST && s.clk_gate[CLK_EN_BIT]) begin
          n.st = SCAN_SWEEP;
          n.col = 3'h0;
          n.idx = 6'h00;
        end
      end
      SCAN_SWEEP: begin
        // First link edge only arms, so column 0 also settles a full period
        if (lk_rise && !s.idx[0]) begin
          n.idx[0] = 1'b1;
        end else if (lk_rise) begin
          n.snap[{s.col, 3'h0} +: NPIN] = col_en[s.col] ? row_hit : 8'h00;
          n.col = 3'(s.col + 1'b1);
          if (s.col == 3'h7) begin
            n.st = SCAN_IDLE;
            if (n.snap != s.cand) begin
              n.cand = n.snap;
              n.stab = 8'h01;
            end else if (s.stab != 8'hFF) begin
              n.stab = 8'(s.stab + 1'b1);
            end
            if (n.stab >= need) begin
              n.st = SCAN_EMIT;
              n.idx = 6'h00;
            end
          end
        end
      end
      SCAN_EMIT: begin
        if (!stall) begin
          if (push) begin
            n.rep[s.idx] = s.cand[s.idx];
            n.sc_flag = 1'b1;
            if (!ev_ready) begin
              n.lost = 1'b1;
            end
            if (press && s.kv != 4'hF) begin
              n.kv[slot] = 1'b1;
              n.kc[slot] = {1'b0, ev_code[6:0]};
              if (slot != 2'h0) begin
                n.kc[2'(slot - 1'b1)][MULTI_BIT] = 1'b1;
              end
            end
          end
          n.idx = 6'(s.idx + 1'b1);
          if (s.idx == 6'h3F) begin
            n.st = SCAN_IDLE;
          end
        end
      end
      default: n.st = SCAN_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign pull_rows = s.pull_r;
  assign pull_cols = s.pull_c;
  assign pin_function = s.pinfn;
  assign matrix_column_pin_o = 8'h00;
  assign matrix_column_pin_oe = (s.st == SCAN_SWEEP && col_en[s.col]) ?
                                (8'h01 << s.col) : 8'h00;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_sweep_onehot: assert property ($onehot0(matrix_column_pin_oe) &&
    (matrix_column_pin_oe == 8'h00 || s.st == SCAN_SWEEP))
    else $error("more than one column driven");
  chk_push_sets_sc: assert property (push |=> s.sc_flag)
    else $error("status change flag not set");
  chk_push_raw_evt: assert property (push && ev_ready |=> raw[RAW_EVT])
    else $error("raw event flag not set after push");
  chk_summary_pin: assert property (host_irq_pin_n ==
    !((ev_valid && s.mask[RAW_EVT]) || (s.sc_flag && s.mask[RAW_SC]) ||
      (s.lost && s.mask[RAW_LOST])))
    else $error("irq pin disagrees with masked raw");
  chk_empty_code: assert property (pop && !ev_valid |=> reg_rdata == EMPTY_CODE)
    else $error("empty event read not 0x7F");
  chk_flush_clear: assert property (flush |=> !ev_valid && !s.lost)
    else $error("flush left events or lost flag");
  chk_code_rd_clr: assert property (code_rd && rd_slot == 2'h0 |=> !s.kv[0])
    else $error("code slot not cleared by read");
  chk_multi_flag: assert property (push && press && s.kv == 4'h1
    |=> s.kv[1] && s.kc[0][MULTI_BIT])
    else $error("second press did not flag slot zero");
  chk_lost_set: assert property (push && !ev_ready |=> s.lost)
    else $error("dropped event did not set lost flag");
  chk_code_valid: assert property (push |-> ev_code != EMPTY_CODE)
    else $error("event code collides with empty code");
  chk_hold_event: assert property (reg_req.addr == A_EVT |-> reg_addr_hold)
    else $error("pointer hold missing on event port");

  cov_event_read: cover property (push ##[1:50] pop && ev_valid);
  cov_lost: cover property (push && !ev_ready);
  cov_four_keys: cover property (s.kv == 4'hF);
endmodule : keypad_scan_event_controller

/* File: verification/keypad_matrix_model.sv */
/*
 * Keypad matrix model: key switches between scanned columns and rows.
 * Assumes columns drive low while enabled and rows carry pull-ups.
 */
`timescale 1ns/1ps
module keypad_matrix_model (
  // Columns from the scanner
  input wire logic [7:0] col_o,
  input wire logic [7:0] col_oe,
  // Held keys, index col*8+row
  input wire logic [63:0] keys,
  // Rows back to the scanner
  output logic [7:0] rows
);
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      // Open row floats up to the pull-up level
      rows[r] = 1'b1;
      for (int c = 0; c < 8; c++) begin
        if (col_oe[c] && !col_o[c] && keys[c*8+r]) begin
          rows[r] = 1'b0;
        end
      end
    end
  end
endmodule : keypad_matrix_model

/* File: verification/keypad_scan_event_controller_tb_top.sv */
/*
 * Self-checking bench for the keypad scan/event controller.
 * Assumes the package, the design and the matrix model are compiled first.
 */
`timescale 1ns/1ps
module keypad_scan_event_controller_tb_top;
  import keyscan_pkg::*;
  // Short scan period keeps the run brief
  localparam int SCAN = 400;
  localparam logic [7:0] CFG_A [12] = '{A_CLK_GATE, A_SETTLE, A_DEBOUNCE, A_DIMS, A_PINS_LO,
    A_PINS_HI, A_PINFN, A_PULLR_LO, A_PULLR_HI, A_PULLC_LO, A_PULLC_HI, A_IRQ_MASK};
  logic mclk;
  logic sys_rst;
  logic link_clk;
  reg_req_type req;
  logic [7:0] rdata;
  logic hold;
  logic [7:0] rows;
  logic [7:0] col_o;
  logic [7:0] col_oe;
  logic [15:0] pull_r;
  logic [15:0] pull_c;
  logic [7:0] pin_fn;
  logic irq_n;
  logic [63:0] keys;
  logic [63:0] nk;
  logic [7:0] cfg_v [12];
  int fails;
  int check_count;
  int r;
  int c;
  // ----------------------------------------------------------------
  // Reference model state
  // ----------------------------------------------------------------
  logic [7:0] regs [256];
  logic [7:0] q [$];
  logic [7:0] slot [4];
  bit sv [4];
  bit sc;
  bit lost;

  keypad_scan_event_controller #(.SCAN_CYCLES(SCAN)) keypad_scan_event_controller_i (
    .mclk(mclk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .reg_addr_hold(hold),
    .link_clk(link_clk), .matrix_row_pin(rows), .matrix_column_pin_o(col_o),
    .matrix_column_pin_oe(col_oe), .pull_rows(pull_r), .pull_cols(pull_c),
    .pin_function(pin_fn), .host_irq_pin_n(irq_n));
  keypad_matrix_model keypad_matrix_model_i (.col_o(col_o), .col_oe(col_oe), .keys(keys),
    .rows(rows));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] m_read(input logic [7:0] a);
    logic [7:0] v;
    logic [2:0] raw;
    raw = {lost, sc, q.size() != 0};
    case (a)
      A_RAW: v = {5'h00, raw};
      A_MASKED: v = {5'h00, raw & regs[A_IRQ_MASK][2:0]};
      A_GLOBAL: v = {7'h00, |raw};
      A_EVT: v = (q.size() != 0) ? q.pop_front() : EMPTY_CODE;
      A_CODE0, 8'h0D, 8'h0E, 8'h0F: begin
        v = sv[a[1:0]] ? slot[a[1:0]] : EMPTY_CODE;
        sv[a[1:0]] = 0;
        if (!(sv[0] | sv[1] | sv[2] | sv[3]) && q.size() == 0) sc = 0;
      end
      default: v = regs[a];
    endcase
    return v;
  endfunction : m_read

  task automatic m_change(input logic [63:0] nx);
    int k;
    logic [7:0] code;
    for (int i = 0; i < 64; i++) begin
      // Rows and columns 7..2 are the assigned matrix
      if (nx[i] != keys[i] && i % 8 >= 2 && i / 8 >= 2) begin
        code = {~nx[i], 1'b0, 3'(i % 8), 3'(i / 8)};
        if (q.size() < FIFO_DEPTH) q.push_back(code);
        else lost = 1;
        sc = 1;
        k = 0;
        while (k < 4 && sv[k]) k++;
        if (nx[i] && k < 4) begin
          slot[k] = code;
          sv[k] = 1;
          if (k > 0) slot[k-1][MULTI_BIT] = 1'b1;
        end
      end
    end
    keys = nx;
  endtask : m_change

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    #1;
    req.wr = 1'b0;
    if (a == A_IRQ_CLR) begin
      if (d[FLUSH_BIT]) q.delete();
      if (d[FLUSH_BIT]) lost = 0;
      if (d[SC_CLR_BIT]) sc = 0;
    end else if (a inside {CFG_A}) begin
      regs[a] = d;
    end
  endtask : wr

  // Reads n times with the strobe held, as in one multi-byte transfer
  task automatic rd(input logic [7:0] a, input int n);
    @(posedge mclk);
    #1;
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    #1;
    if (a == A_EVT) chk(16'(hold), 16'h0001);
    for (int j = 0; j < n; j++) begin
      @(posedge mclk);
      #1;
      if (j == n - 1) req.rd = 1'b0;
      chk(16'(rdata), 16'(m_read(a)));
    end
  endtask : rd

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < 20 * SCAN) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(irq_n), 16'h0000);
    // Emission of one scan takes 64 cycles
    repeat (100) @(posedge mclk);
  endtask : wait_irq

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    #400000;
    fails++;
    $display("watchdog expired at %0t", $time);
    summarize();
  end

  initial begin
    fails = 0;
    check_count = 0;
    sc = 0;
    lost = 0;
    keys = '0;
    foreach (regs[i]) regs[i] = 8'h00;
    foreach (sv[i]) sv[i] = 0;
    req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    sys_rst = 1'b1;
    void'($urandom(80080));
    cfg_v = '{8'h01, 8'h00, 8'h00, 8'h88, 8'h3F, 8'hFC, 8'hF8, 8'hAA, 8'hAA, 8'h55, 8'h55,
      8'h07};
    // Settle and debounce small enough for a single stable scan
    cfg_v[1] = 8'($urandom_range(42, 0));
    cfg_v[2] = 8'($urandom_range(42, 0));
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    foreach (CFG_A[i]) rd(CFG_A[i], 1);
    rd(8'h55, 1);
    rd(A_EVT, 1);
    rd(A_RAW, 1);
    chk(16'(irq_n), 16'h0001);
    $display("test reset done");
    foreach (CFG_A[i]) wr(CFG_A[i], cfg_v[i]);
    wr(A_IRQ_CLR, 8'h03);
    wr(8'h55, 8'($urandom));
    foreach (CFG_A[i]) rd(CFG_A[i], 1);
    rd(8'h55, 1);
    chk(pull_r, 16'hAAAA);
    chk(pull_c, 16'h5555);
    chk(16'(pin_fn), 16'h00F8);
    $display("test setup done");
    r = $urandom_range(7, 2);
    c = $urandom_range(7, 2);
    nk = '0;
    nk[c*8+r] = 1'b1;
    // Row 0 is outside the assigned matrix
    nk[24] = 1'b1;
    m_change(nk);
    wait_irq();
    rd(A_GLOBAL, 1);
    rd(A_MASKED, 1);
    rd(A_CODE0, 1);
    rd(A_EVT, 2);
    rd(A_RAW, 1);
    wr(A_IRQ_MASK, 8'h01);
    rd(A_MASKED, 1);
    chk(16'(irq_n), 16'h0001);
    wr(A_IRQ_MASK, 8'h07);
    rd(A_CODE0, 1);
    rd(A_RAW, 1);
    chk(16'(irq_n), 16'h0001);
    nk = '0;
    m_change(nk);
    wait_irq();
    rd(A_EVT, 2);
    rd(A_CODE0, 1);
    rd(A_RAW, 1);
    $display("test single key done");
    c = $urandom_range(7, 2);
    nk = 64'h7C << (c * 8);
    m_change(nk);
    wait_irq();
    for (int i = 0; i < 4; i++) rd(A_CODE0 + 8'(i), 1);
    rd(A_RAW, 1);
    wr(A_IRQ_CLR, 8'h01);
    rd(A_EVT, 1);
    rd(A_RAW, 1);
    // Status change still pending would hide the release interrupt
    wr(A_IRQ_CLR, 8'h02);
    chk(16'(irq_n), 16'h0001);
    nk = '0;
    m_change(nk);
    wait_irq();
    rd(A_EVT, 3);
    wr(A_IRQ_CLR, 8'h03);
    rd(A_RAW, 1);
    chk(16'(irq_n), 16'h0001);
    $display("test multi key done");
    summarize();
  end
endmodule : keypad_scan_event_controller_tb_top
